// >>> common/nvm_array_if.sv
// interface: controller to flash array program/erase handshake
`timescale 1ns/100ps
interface nvm_array_if;
   logic start;
   logic erase;
   logic [12:0] addr;
   logic [55:0] data;
   logic busy;
   logic done;
   modport ctrl (output start, output erase, output addr, output data, input busy, input done);
   modport timer (input start, input erase, input addr, input data, output busy, output done);
endinterface

// >>> common/nvm_ctrl_pkg.sv
// package: register offsets, bit positions, reset values and timing for the flash self-write block
package nvm_ctrl_pkg;
   // register offsets on the core's register file bus
   localparam logic [8:0] off_irq_flags_2 = 9'h00d;
   localparam logic [8:0] off_irq_enables_2 = 9'h08d;
   localparam logic [8:0] off_data_low = 9'h10c;
   localparam logic [8:0] off_address_low = 9'h10d;
   localparam logic [8:0] off_data_high = 9'h10e;
   localparam logic [8:0] off_address_high = 9'h10f;
   localparam logic [8:0] off_control = 9'h18c;
   localparam logic [8:0] off_unlock_port = 9'h18d;
   // control register bit positions
   localparam int bit_rd = 0;
   localparam int bit_wr = 1;
   localparam int bit_write_enable_bit = 2;
   localparam int bit_write_error_bit = 3;
   localparam int bit_free = 4;
   localparam int bit_pgd = 7;
   // write-complete flag / enable position in the peripheral irq registers
   localparam int bit_wc_flag = 4;
   // unlock keys
   localparam logic [7:0] unlock_key_1 = 8'h55;
   localparam logic [7:0] unlock_key_2 = 8'haa;
   // buffer geometry and erased value
   localparam int buf_words = 4;
   localparam int word_bits = 14;
   localparam logic [13:0] erased_word = 14'h3fff;
   localparam logic [1:0] last_slot = 2'h3;
   localparam int row_low_bits = 5;
   // reset values
   localparam logic [7:0] irq_reset = 8'h00;
   // timing at 25 MHz
   localparam int clk_mhz = 25;
   localparam int prog_time_us = 2000;
   localparam int prog_cycles = prog_time_us * clk_mhz;
   localparam int pwrt_time_ms = 72;
   localparam int pwrt_cycles = pwrt_time_ms * 1000 * clk_mhz;
   // core pipeline: one instruction runs, one is discarded before the halt
   localparam int setup_cycles = 2;
endpackage

// >>> hdl/nvm_op_timer.sv
// operation timer: counts the long program or erase time after a start
`timescale 1ns/100ps
module nvm_op_timer #(
   parameter int op_cycles = nvm_ctrl_pkg::prog_cycles
) (
   input wire logic clk,
   input wire logic arst_n,
   nvm_array_if.timer arr
);
   logic [31:0] cnt_ff;
   logic busy_ff;
   logic done_ff;

   // single run counter; a new start while busy is not possible by design
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_ff <= 32'h0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         if (arr.start && !busy_ff) begin
            busy_ff <= 1'b1;
            cnt_ff <= 32'(op_cycles - 1);
         end else if (busy_ff) begin
            if (cnt_ff == 32'h0) begin
               busy_ff <= 1'b0;
               done_ff <= 1'b1;
            end else begin
               cnt_ff <= cnt_ff - 32'h1;
            end
         end
      end
   end

   assign arr.busy = busy_ff;
   assign arr.done = done_ff;
endmodule // nvm_op_timer

// >>> hdl/program_flash_self_write_ctrl.sv
// flash self-write controller: buffer loads, four-word programs, row erases, core stall
`timescale 1ns/100ps
module program_flash_self_write_ctrl #(
   parameter int op_cycles = nvm_ctrl_pkg::prog_cycles,
   parameter int pwrt_cycles = nvm_ctrl_pkg::pwrt_cycles
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic por_n,
   input wire logic [8:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic [1:0] write_protect_field,
   input wire logic [12:0] protect_limit,
   input wire logic program_protect,
   input wire logic data_protect,
   input wire logic ext_access_req,
   input wire logic ext_to_eeprom,
   input wire logic ext_write,
   output logic ext_access_ok,
   output logic discard_next,
   output logic core_halt_signal,
   output logic write_complete_flag,
   output logic write_complete_irq_enable,
   output logic array_start,
   output logic array_erase,
   output logic [12:0] array_addr,
   output logic [55:0] array_data
);
   typedef enum logic [1:0] {st_idle, st_setup, st_busy} op_state_t;

   op_state_t state_ff;
   logic [7:0] data_low_ff;
   logic [5:0] data_high_ff;
   logic [7:0] address_low_ff;
   logic [4:0] address_high_ff;
   logic program_memory_select_ff;
   logic erase_select_ff;
   logic write_enable_bit_ff;
   logic write_error_bit_ff;
   logic wr_ff;
   logic wc_flag_ff;
   logic wc_ie_ff;
   logic [1:0] unlock_ff;
   logic [13:0] buf_ff [nvm_ctrl_pkg::buf_words];
   logic [1:0] setup_cnt_ff;
   logic pwrt_done_ff;
   logic [31:0] pwrt_cnt_ff;
   logic active_ff;
   logic is_erase_ff;
   logic [12:0] tgt_addr;
   logic wr_ctl;
   logic wr_unlock;
   logic start_req;
   logic start_ok;
   logic slot_last;
   logic [12:0] full_addr;
   logic protected_hit;
   logic op_done;
   logic [55:0] flat_buf;

   nvm_array_if arr();

   nvm_op_timer #(.op_cycles(op_cycles)) u_timer (
      .clk(clk),
      .arst_n(arst_n),
      .arr(arr.timer)
   );

   assign full_addr = {address_high_ff, address_low_ff};
   assign tgt_addr = erase_select_ff ? {full_addr[12:5], 5'h00} : {full_addr[12:2], 2'b00};
   assign wr_ctl = reg_wr && (reg_addr == nvm_ctrl_pkg::off_control);
   assign wr_unlock = reg_wr && (reg_addr == nvm_ctrl_pkg::off_unlock_port);
   assign slot_last = (address_low_ff[1:0] == nvm_ctrl_pkg::last_slot);
   assign op_done = arr.done;

   // protected span from address 0: limit times 1, 2, 4; code 11 protects none
   // base of group or row is checked, so a partly protected target is refused too
   always_comb begin
      case (write_protect_field)
         2'h0: protected_hit = tgt_addr < protect_limit;
         2'h1: protected_hit = {1'b0, tgt_addr} < {protect_limit, 1'b0};
         2'h2: protected_hit = {2'b00, tgt_addr} < {protect_limit, 2'b00};
         default: protected_hit = 1'b0;
      endcase
   end

   // start request: write of 1 to the start bit with enable, unlock and no busy op
   assign start_req = wr_ctl && reg_wdata[nvm_ctrl_pkg::bit_wr];
   assign start_ok = start_req && write_enable_bit_ff
      && (unlock_ff == 2'h2) && pwrt_done_ff
      && program_memory_select_ff && (state_ff == st_idle) && !wr_ff;

   // unlock recogniser; the port stores nothing, only the sequence state
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         unlock_ff <= 2'h0;
      end else if (wr_unlock) begin
         if (reg_wdata == nvm_ctrl_pkg::unlock_key_1) begin
            unlock_ff <= 2'h1;
         end else if (reg_wdata == nvm_ctrl_pkg::unlock_key_2 && unlock_ff == 2'h1) begin
            unlock_ff <= 2'h2;
         end else begin
            unlock_ff <= 2'h0;
         end
      end else if (wr_ctl) begin
         unlock_ff <= 2'h0; // any control write consumes or breaks the sequence
      end
   end

   // power-up timer; power-on reset restarts it, other resets do not
   always_ff @(posedge clk or negedge por_n) begin
      if (!por_n) begin
         pwrt_cnt_ff <= 32'h0;
         pwrt_done_ff <= 1'b0;
      end else if (!pwrt_done_ff) begin
         if (pwrt_cnt_ff == 32'(pwrt_cycles - 1)) begin
            pwrt_done_ff <= 1'b1;
         end else begin
            pwrt_cnt_ff <= pwrt_cnt_ff + 32'h1;
         end
      end
   end

   // address and data registers; data registers keep contents through resets
   always_ff @(posedge clk) begin
      if (reg_wr && reg_addr == nvm_ctrl_pkg::off_data_low) begin
         data_low_ff <= reg_wdata;
      end
      if (reg_wr && reg_addr == nvm_ctrl_pkg::off_data_high) begin
         data_high_ff <= reg_wdata[5:0];
      end
      if (reg_wr && reg_addr == nvm_ctrl_pkg::off_address_low) begin
         address_low_ff <= reg_wdata;
      end
      if (reg_wr && reg_addr == nvm_ctrl_pkg::off_address_high) begin
         address_high_ff <= reg_wdata[4:0];
      end
   end

   // control bits; enable cleared on power-on only, as the other resets leave it
   always_ff @(posedge clk or negedge por_n) begin
      if (!por_n) begin
         write_enable_bit_ff <= 1'b0;
         program_memory_select_ff <= 1'b0;
         erase_select_ff <= 1'b0;
      end else if (wr_ctl) begin
         write_enable_bit_ff <= reg_wdata[nvm_ctrl_pkg::bit_write_enable_bit];
         program_memory_select_ff <= reg_wdata[nvm_ctrl_pkg::bit_pgd];
         erase_select_ff <= reg_wdata[nvm_ctrl_pkg::bit_free];
      end
   end

   // tracks a running operation so a warm reset can report it
   always_ff @(posedge clk or negedge por_n) begin
      if (!por_n) begin
         active_ff <= 1'b0;
      end else if (!arst_n) begin
         active_ff <= 1'b0;
      end else begin
         active_ff <= (state_ff != st_idle);
      end
   end

   // error bit: set by an aborted operation, cleared by software writing 0
   always_ff @(posedge clk or negedge por_n) begin
      if (!por_n) begin
         write_error_bit_ff <= 1'b0;
      end else if (active_ff && !arst_n) begin
         write_error_bit_ff <= 1'b1;
      end else if (wr_ctl && !reg_wdata[nvm_ctrl_pkg::bit_write_error_bit]) begin
         write_error_bit_ff <= 1'b0;
      end
   end

   // operation sequencer: setup lets one instruction run, one is discarded, then halt
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_ff <= st_idle;
         setup_cnt_ff <= 2'h0;
         wr_ff <= 1'b0;
         is_erase_ff <= 1'b0;
      end else begin
         case (state_ff)
            st_idle: begin
               wr_ff <= 1'b0;
               if (start_ok) begin
                  if (erase_select_ff) begin
                     wr_ff <= !protected_hit;
                     is_erase_ff <= 1'b1;
                     if (!protected_hit) begin
                        state_ff <= st_setup;
                     end
                  end else if (slot_last) begin
                     wr_ff <= !protected_hit;
                     is_erase_ff <= 1'b0;
                     if (!protected_hit) begin
                        state_ff <= st_setup;
                     end
                  end else begin
                     wr_ff <= 1'b1; // short load, clears next cycle
                  end
                  setup_cnt_ff <= 2'(nvm_ctrl_pkg::setup_cycles - 1);
               end
            end
            st_setup: begin
               if (setup_cnt_ff == 2'h0) begin
                  state_ff <= st_busy;
               end else begin
                  setup_cnt_ff <= setup_cnt_ff - 2'h1;
               end
            end
            st_busy: begin
               if (op_done) begin
                  state_ff <= st_idle;
                  wr_ff <= 1'b0;
               end
            end
            default: state_ff <= st_idle;
         endcase
      end
   end

   // write buffer: load by slot, preset to erased value after every long write
   generate
      for (genvar i = 0; i < nvm_ctrl_pkg::buf_words; i++) begin : g_buf
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               buf_ff[i] <= nvm_ctrl_pkg::erased_word;
            end else if (state_ff == st_busy && op_done && !is_erase_ff) begin
               buf_ff[i] <= nvm_ctrl_pkg::erased_word;
            end else if (start_ok && !erase_select_ff && address_low_ff[1:0] == 2'(i)) begin
               buf_ff[i] <= {data_high_ff, data_low_ff};
            end
         end
         assign flat_buf[i*nvm_ctrl_pkg::word_bits +: nvm_ctrl_pkg::word_bits] = buf_ff[i];
      end
   endgenerate

   // array command: launched when setup ends; group address forced to aligned base
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         array_start <= 1'b0;
         array_erase <= 1'b0;
         array_addr <= 13'h0;
         array_data <= 56'h0;
      end else begin
         array_start <= (state_ff == st_setup) && (setup_cnt_ff == 2'h0);
         if (state_ff == st_setup) begin
            array_erase <= is_erase_ff;
            if (is_erase_ff) begin
               array_addr <= {full_addr[12:nvm_ctrl_pkg::row_low_bits], 5'h00};
            end else begin
               array_addr <= {full_addr[12:2], 2'b00};
               array_data <= flat_buf;
            end
         end
      end
   end

   assign arr.start = array_start;
   assign arr.erase = array_erase;
   assign arr.addr = array_addr;
   assign arr.data = array_data;

   // completion flag: hardware set wins over a software clear in the same cycle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wc_flag_ff <= 1'b0;
         wc_ie_ff <= 1'b0;
      end else begin
         if (state_ff == st_busy && op_done) begin
            wc_flag_ff <= 1'b1;
         end else if (reg_wr && reg_addr == nvm_ctrl_pkg::off_irq_flags_2) begin
            wc_flag_ff <= reg_wdata[nvm_ctrl_pkg::bit_wc_flag];
         end
         if (reg_wr && reg_addr == nvm_ctrl_pkg::off_irq_enables_2) begin
            wc_ie_ff <= reg_wdata[nvm_ctrl_pkg::bit_wc_flag];
         end
      end
   end

   // core stall during the timed operation; discard marks the instruction after the next
   assign core_halt_signal = (state_ff == st_busy);
   assign discard_next = (state_ff == st_setup) && (setup_cnt_ff == 2'h0);
   assign write_complete_flag = wc_flag_ff;
   assign write_complete_irq_enable = wc_ie_ff;

   // external gating under code protection; internal paths unaffected
   always_comb begin
      ext_access_ok = ext_access_req;
      if (ext_to_eeprom && data_protect) begin
         ext_access_ok = 1'b0;
      end
      if (!ext_to_eeprom && ext_write && data_protect) begin
         ext_access_ok = 1'b0;
      end
      if (!ext_to_eeprom && program_protect) begin
         ext_access_ok = 1'b0;
      end
   end

   // register read mux; unlock port and unmapped offsets read zero
   always_comb begin
      reg_rdata = 8'h00;
      case (reg_addr)
         nvm_ctrl_pkg::off_irq_flags_2: reg_rdata[nvm_ctrl_pkg::bit_wc_flag] = wc_flag_ff;
         nvm_ctrl_pkg::off_irq_enables_2: reg_rdata[nvm_ctrl_pkg::bit_wc_flag] = wc_ie_ff;
         nvm_ctrl_pkg::off_data_low: reg_rdata = data_low_ff;
         nvm_ctrl_pkg::off_address_low: reg_rdata = address_low_ff;
         nvm_ctrl_pkg::off_data_high: reg_rdata = {2'b00, data_high_ff};
         nvm_ctrl_pkg::off_address_high: reg_rdata = {3'b000, address_high_ff};
         nvm_ctrl_pkg::off_control: begin
            reg_rdata[nvm_ctrl_pkg::bit_pgd] = program_memory_select_ff;
            reg_rdata[nvm_ctrl_pkg::bit_free] = erase_select_ff;
            reg_rdata[nvm_ctrl_pkg::bit_write_error_bit] = write_error_bit_ff;
            reg_rdata[nvm_ctrl_pkg::bit_write_enable_bit] = write_enable_bit_ff;
            reg_rdata[nvm_ctrl_pkg::bit_wr] = wr_ff;
         end
         default: reg_rdata = 8'h00;
      endcase
   end
endmodule // program_flash_self_write_ctrl

// >>> testbench/flash_array_model.sv
// partner model: flash array that records program and erase requests
`timescale 1ns/100ps
module flash_array_model (
   input wire logic clk,
   input wire logic array_start,
   input wire logic array_erase,
   input wire logic [12:0] array_addr,
   input wire logic [55:0] array_data,
   output int op_count,
   output int bad_count,
   output logic [55:0] seen_data,
   output logic [12:0] seen_addr,
   output logic seen_erase
);
   logic [255:0] erased;
   initial begin
      op_count = 0;
      bad_count = 0;
      erased = '0;
   end
   // latch each request; a program must land on an erased row and an aligned group
   always @(posedge clk) begin
      if (array_start === 1'b1) begin
         op_count <= op_count + 1;
         seen_data <= array_data;
         seen_addr <= array_addr;
         seen_erase <= array_erase;
         if (array_erase) begin
            erased[array_addr[12:5]] <= 1'b1;
         end else if (array_addr[1:0] != 2'h0 || !erased[array_addr[12:5]]) begin
            bad_count <= bad_count + 1;
         end
      end
   end
endmodule // flash_array_model

// >>> testbench/program_flash_self_write_ctrl_chk.sv
// checker: port relations of the flash self-write controller
`timescale 1ns/100ps
module program_flash_self_write_ctrl_chk #(
   parameter int op_cycles = 8
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic por_n,
   input wire logic [1:0] write_protect_field,
   input wire logic [12:0] protect_limit,
   input wire logic program_protect,
   input wire logic data_protect,
   input wire logic ext_access_req,
   input wire logic ext_to_eeprom,
   input wire logic ext_write,
   input wire logic ext_access_ok,
   input wire logic discard_next,
   input wire logic core_halt_signal,
   input wire logic write_complete_flag,
   input wire logic array_start,
   input wire logic array_erase,
   input wire logic [12:0] array_addr
);
   logic [15:0] prot_top;
   logic [31:0] halt_cnt_ff;
   // first unprotected word; field 11 leaves the whole array open
   assign prot_top = (write_protect_field == 2'h3) ? 16'h0000
      : ({3'h0, protect_limit} << write_protect_field);
   // halt length counted here, too long for a repetition
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         halt_cnt_ff <= 32'h0;
      end else begin
         halt_cnt_ff <= core_halt_signal ? halt_cnt_ff + 32'h1 : 32'h0;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n || !por_n);
   a_start_one_pulse: assert property (array_start |=> !array_start)
      else $error("array start longer than one cycle");
   a_start_halts_core: assert property (array_start |-> core_halt_signal)
      else $error("array start without core halt");
   a_halt_needs_start: assert property ($rose(core_halt_signal) |-> array_start)
      else $error("core halt without array start");
   a_discard_then_start: assert property (discard_next |=> array_start)
      else $error("discard not followed by array start");
   a_halt_bounded: assert property (halt_cnt_ff <= op_cycles + 2)
      else $error("core halt too long");
   a_flag_at_done: assert property ($fell(core_halt_signal) |-> ##[0:1] write_complete_flag)
      else $error("no completion flag after operation");
   a_group_aligned: assert property (array_start && !array_erase |-> array_addr[1:0] == 2'h0)
      else $error("program group not aligned");
   a_row_aligned: assert property (array_start && array_erase |-> array_addr[4:0] == 5'h00)
      else $error("erase row not aligned");
   a_protect_refuse: assert property (array_start |-> {3'h0, array_addr} >= prot_top)
      else $error("operation inside protected span");
   a_ext_data_block: assert property (ext_access_req && data_protect
      && (ext_to_eeprom || ext_write) |-> !ext_access_ok)
      else $error("external access granted under data protect");
   a_ext_prog_block: assert property (ext_access_req && program_protect
      && !ext_to_eeprom |-> !ext_access_ok)
      else $error("external access granted under program protect");
   c_program: cover property (array_start && !array_erase);
   c_erase: cover property (array_start && array_erase);
   c_done: cover property ($fell(core_halt_signal));
endmodule // program_flash_self_write_ctrl_chk
bind program_flash_self_write_ctrl program_flash_self_write_ctrl_chk #(.op_cycles(op_cycles)) u_chk (
   .clk(clk), .arst_n(arst_n), .por_n(por_n), .write_protect_field(write_protect_field),
   .protect_limit(protect_limit), .program_protect(program_protect),
   .data_protect(data_protect), .ext_access_req(ext_access_req),
   .ext_to_eeprom(ext_to_eeprom), .ext_write(ext_write), .ext_access_ok(ext_access_ok),
   .discard_next(discard_next), .core_halt_signal(core_halt_signal),
   .write_complete_flag(write_complete_flag), .array_start(array_start),
   .array_erase(array_erase), .array_addr(array_addr));

// >>> testbench/tb_program_flash_self_write_ctrl.sv
// testbench: register-driven loads, programs, erases, protection and resets
`timescale 1ns/100ps
module tb_program_flash_self_write_ctrl;
   localparam int op_n = 8;
   logic clk, arst_n, por_n, reg_wr, program_protect, data_protect;
   logic ext_access_req, ext_to_eeprom, ext_write, ext_access_ok, discard_next;
   logic core_halt_signal, write_complete_flag, write_complete_irq_enable;
   logic array_start, array_erase, seen_erase;
   logic [8:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, rv;
   logic [1:0] write_protect_field;
   logic [12:0] protect_limit, array_addr, seen_addr;
   logic [55:0] array_data, seen_data;
   logic [13:0] w [0:4];
   int err_count, checks_done, op_count, bad_count, ops, d, h, s;
   program_flash_self_write_ctrl #(.op_cycles(op_n), .pwrt_cycles(4)) u_dut (
      .clk(clk), .arst_n(arst_n), .por_n(por_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .write_protect_field(write_protect_field),
      .protect_limit(protect_limit), .program_protect(program_protect),
      .data_protect(data_protect), .ext_access_req(ext_access_req),
      .ext_to_eeprom(ext_to_eeprom), .ext_write(ext_write), .ext_access_ok(ext_access_ok),
      .discard_next(discard_next), .core_halt_signal(core_halt_signal),
      .write_complete_flag(write_complete_flag),
      .write_complete_irq_enable(write_complete_irq_enable), .array_start(array_start),
      .array_erase(array_erase), .array_addr(array_addr), .array_data(array_data));
   flash_array_model u_flash (.clk(clk), .array_start(array_start), .array_erase(array_erase),
      .array_addr(array_addr), .array_data(array_data), .op_count(op_count),
      .bad_count(bad_count), .seen_data(seen_data), .seen_addr(seen_addr),
      .seen_erase(seen_erase));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic chk(input string what, input logic [95:0] exp, input logic [95:0] got);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one write strobe per call, dropped a cycle later
   task automatic wreg(input logic [8:0] a, input logic [7:0] v);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask
   task automatic rreg(input logic [8:0] a);
      @(negedge clk);
      reg_addr = a;
      #1 rv = reg_rdata;
   endtask
   task automatic setw(input logic [12:0] a, input logic [13:0] v);
      wreg(nvm_ctrl_pkg::off_address_high, {3'h0, a[12:8]});
      wreg(nvm_ctrl_pkg::off_address_low, a[7:0]);
      wreg(nvm_ctrl_pkg::off_data_low, v[7:0]);
      wreg(nvm_ctrl_pkg::off_data_high, {2'h0, v[13:8]});
   endtask
   task automatic launch(input logic [7:0] ctl);
      wreg(nvm_ctrl_pkg::off_control, ctl & 8'hfd);
      wreg(nvm_ctrl_pkg::off_unlock_port, 8'h55);
      wreg(nvm_ctrl_pkg::off_unlock_port, 8'haa);
      wreg(nvm_ctrl_pkg::off_control, ctl);
   endtask
   // samples from the cycle after the start write; reg_addr still on control
   task automatic watch();
      int n;
      n = op_count;
      d = 0;
      h = 0;
      s = 0;
      repeat (op_n + 12) begin
         if (discard_next === 1'b1) d++;
         if (core_halt_signal === 1'b1) h++;
         if (reg_rdata[nvm_ctrl_pkg::bit_wr] === 1'b1) s++;
         @(negedge clk);
      end
      ops = op_count - n;
   endtask
   task automatic t_reset_values();
      rreg(nvm_ctrl_pkg::off_irq_flags_2);
      chk("irq_flags", 8'h00, rv);
      rreg(nvm_ctrl_pkg::off_irq_enables_2);
      chk("irq_enables", 8'h00, rv);
      rreg(nvm_ctrl_pkg::off_control);
      chk("write_enable_bit_reset", 1'b0, rv[nvm_ctrl_pkg::bit_write_enable_bit]);
      wreg(nvm_ctrl_pkg::off_unlock_port, 8'h55);
      rreg(nvm_ctrl_pkg::off_unlock_port);
      chk("unlock_read", 8'h00, rv);
   endtask
   task automatic t_refusals();
      launch(8'h82);
      watch();
      chk("no_write_enable_bit_start", 0, {ops, s});
      wreg(nvm_ctrl_pkg::off_unlock_port, 8'haa);
      wreg(nvm_ctrl_pkg::off_unlock_port, 8'h55);
      wreg(nvm_ctrl_pkg::off_control, 8'h86);
      watch();
      chk("bad_key_order", 0, ops);
      wreg(nvm_ctrl_pkg::off_unlock_port, 8'h55);
      wreg(nvm_ctrl_pkg::off_control, 8'h84);
      wreg(nvm_ctrl_pkg::off_unlock_port, 8'haa);
      wreg(nvm_ctrl_pkg::off_control, 8'h86);
      watch();
      chk("ctrl_between_keys", 0, ops);
   endtask
   task automatic t_erase();
      setw(13'h14b, 14'h0000);
      launch(8'h96);
      watch();
      chk("erase_ops", {32'd1, 32'd1}, {ops, d});
      chk("erase_halt", op_n + 2, h);
      chk("erase_target", {1'b1, 13'h140}, {seen_erase, seen_addr});
      chk("erase_flag", 1'b1, write_complete_flag);
      rreg(nvm_ctrl_pkg::off_control);
      chk("erase_wr_clear", 1'b0, rv[nvm_ctrl_pkg::bit_wr]);
      wreg(nvm_ctrl_pkg::off_irq_flags_2, 8'h00);
      chk("flag_cleared", 1'b0, write_complete_flag);
      wreg(nvm_ctrl_pkg::off_irq_enables_2, 8'h10);
      rreg(nvm_ctrl_pkg::off_irq_enables_2);
      chk("irq_enable", {1'b1, 8'h10}, {write_complete_irq_enable, rv});
   endtask
   task automatic t_program();
      for (int i = 0; i < 3; i++) begin
         setw(13'h140 + 13'(i), w[i]);
         launch(8'h86);
         watch();
         chk("short_load", {32'd0, 32'd0, 32'd1}, {ops, h, s});
      end
      setw(13'h143, w[3]);
      launch(8'h86);
      watch();
      chk("long_ops", {32'd1, 32'd1, 32'(op_n + 2)}, {ops, d, h});
      chk("long_data", {w[3], w[2], w[1], w[0]}, seen_data);
      chk("long_addr", {1'b0, 13'h140}, {seen_erase, seen_addr});
      setw(13'h147, w[4]);
      launch(8'h86);
      watch();
      chk("preset_data", {w[4], {3{nvm_ctrl_pkg::erased_word}}}, seen_data);
      chk("preset_addr", 13'h144, seen_addr);
      chk("array_misuse", 0, bad_count);
   endtask
   task automatic t_protect();
      write_protect_field = 2'h0;
      setw(13'h0c3, 14'h0123);
      launch(8'h86);
      watch();
      chk("prot_program", 0, ops);
      launch(8'h96);
      watch();
      chk("prot_erase", 0, ops);
      write_protect_field = 2'h3;
   endtask
   task automatic t_external();
      for (int i = 0; i < 16; i++) begin
         @(negedge clk);
         {data_protect, program_protect, ext_to_eeprom, ext_write} = 4'(i);
         ext_access_req = 1'b1;
         #1 chk("ext_grant", !((data_protect && (ext_to_eeprom || ext_write))
            || (program_protect && !ext_to_eeprom)), ext_access_ok);
      end
      ext_access_req = 1'b0;
   endtask
   task automatic t_resets();
      setw(13'h160, 14'h0000);
      launch(8'h96);
      repeat (5) @(negedge clk);
      arst_n = 1'b0;
      repeat (2) @(negedge clk);
      arst_n = 1'b1;
      rreg(nvm_ctrl_pkg::off_control);
      chk("error_bit", {1'b1, 1'b0}, {rv[nvm_ctrl_pkg::bit_write_error_bit], core_halt_signal});
      wreg(nvm_ctrl_pkg::off_control, 8'h84);
      rreg(nvm_ctrl_pkg::off_control);
      chk("error_clear", 1'b0, rv[nvm_ctrl_pkg::bit_write_error_bit]);
      por_n = 1'b0;
      arst_n = 1'b0;
      repeat (2) @(negedge clk);
      por_n = 1'b1;
      arst_n = 1'b1;
      rreg(nvm_ctrl_pkg::off_control);
      chk("por_write_enable_bit", 1'b0, rv[nvm_ctrl_pkg::bit_write_enable_bit]);
   endtask
   task automatic report_and_stop();
      if (err_count == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // watchdog: the sequence needs well under 3000 cycles
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      report_and_stop();
   end
   initial begin
      {arst_n, por_n, reg_wr, program_protect, data_protect} = 5'h00;
      {ext_access_req, ext_to_eeprom, ext_write} = 3'h0;
      reg_addr = 9'h000;
      reg_wdata = 8'h00;
      write_protect_field = 2'h3;
      protect_limit = 13'h0100;
      w = '{14'h1a5c, 14'h2b6d, 14'h0c7e, 14'h3d8f, 14'h2001};
      repeat (16) @(negedge clk);
      {arst_n, por_n} = 2'h3;
      repeat (8) @(negedge clk);
      t_reset_values();
      t_refusals();
      t_erase();
      t_program();
      t_protect();
      t_external();
      t_resets();
      report_and_stop();
   end
endmodule // tb_program_flash_self_write_ctrl
